// ==== src/dmat_params.svh ====
`ifndef DMAT_PARAMS_SVH
`define DMAT_PARAMS_SVH

// register addresses on the special-function register port
`define DMAT_ADDR_CTRL 8'hC8
`define DMAT_ADDR_RLD_LO 8'hCA
`define DMAT_ADDR_RLD_HI 8'hCB
`define DMAT_ADDR_CNT_LO 8'hCC
`define DMAT_ADDR_CNT_HI 8'hCD

// control register field positions
`define DMAT_BIT_HOF 7
`define DMAT_BIT_LOF 6
`define DMAT_BIT_LIEN 5
`define DMAT_BIT_UNUSED_HI 4
`define DMAT_BIT_SPLIT 3
`define DMAT_BIT_RUN 2
`define DMAT_BIT_UNUSED_LO 1
`define DMAT_BIT_XSEL 0

// reset and boundary values
`define DMAT_BYTE_RESET 8'h00
`define DMAT_BYTE_MAX 8'hFF
`define DMAT_WORD_MAX 16'hFFFF
`define DMAT_WORD_ONE 16'h0001
`define DMAT_BYTE_ONE 8'h01

// clock prescaler figures
`define DMAT_SYS_DIV 12
`define DMAT_EXT_DIV 8

`endif

// ==== src/dmat_pkg.sv ====
package dmat_pkg;

	// clock source for one count byte
	typedef enum logic [1:0] {
		DMAT_SRC_SYS,
		DMAT_SRC_DIV12,
		DMAT_SRC_EXT8
	} dmat_src_t;

	// operating mode of the counter
	typedef enum logic {
		DMAT_MODE_WIDE,
		DMAT_MODE_SPLIT
	} dmat_mode_t;

endpackage : dmat_pkg

// ==== src/dmat_tick_gen.sv ====
`timescale 1ns/100ps
`include "dmat_params.svh"

module dmat_tick_gen
	#(
	parameter int unsigned SYS_DIV = `DMAT_SYS_DIV,
	parameter int unsigned EXT_DIV = `DMAT_EXT_DIV
	)
	(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic ext_clk_i,
	output logic div12_tick_o,
	output logic ext8_tick_o
	);

	localparam int unsigned SW = $clog2(SYS_DIV);
	localparam int unsigned EW = $clog2(EXT_DIV);
	localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIV - 1);
	localparam logic [EW-1:0] EXT_LAST = EW'(EXT_DIV - 1);

	logic [SW-1:0] sys_cnt;
	logic [EW-1:0] ext_cnt;
	logic ext_meta;
	logic ext_sync;
	logic ext_prev;

	// system clock prescaler, one tick per SYS_DIV cycles
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sys_cnt <= '0;
			div12_tick_o <= 1'b0;
		end
		else
		begin
			div12_tick_o <= (sys_cnt == SYS_LAST);
			sys_cnt <= (sys_cnt == SYS_LAST) ? '0 : sys_cnt + SW'(1);
		end
	end

	// pin synchroniser; only the second and third stages feed logic
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
			ext_prev <= 1'b0;
		end
		else
		begin
			ext_meta <= ext_clk_i;
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
		end
	end

	// divide rising edges of the synced pin; ext clock must not outrun mclk
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ext_cnt <= '0;
			ext8_tick_o <= 1'b0;
		end
		else
		begin
			ext8_tick_o <= 1'b0;
			if (ext_sync && !ext_prev)
			begin
				ext8_tick_o <= (ext_cnt == EXT_LAST); // [R11]
				ext_cnt <= (ext_cnt == EXT_LAST) ? '0 : ext_cnt + EW'(1);
			end
		end
	end

endmodule : dmat_tick_gen

// ==== src/dmat_timer.sv ====
`timescale 1ns/100ps
`include "dmat_params.svh"

// Function
// (R1) count is two software-visible bytes forming one sixteen-bit value
// (R2) control bit 3 picks sixteen-bit mode (0) or two eight-bit timers (1)
// (R3) sixteen-bit wrap past FFFF reloads count and sets high overflow flag
// (R4) with timer interrupt enabled, each sixteen-bit overflow interrupts
// (R5) with low interrupt enable too, low-byte wraps also interrupt
// (R6) split mode: each half counts and reloads from its own reload byte
// (R7) split mode: run bit gates only the high half; low half always counts
// (R8) sixteen-bit mode: run bit starts and stops the whole timer
// (R9) per-byte select: 1 gives system clock, 0 defers to external select
// (R10) external select bit 0: sysclk/12 when 0, external clock/8 when 1
// (R11) external clock/8 is synchronised to system clock before counting
// (R12) split mode: each half sets its own overflow flag on wrap
// (R13) low overflow flag sets on every low-byte wrap in both modes
// (R14) split mode: high half interrupts; with low enable, either half does
// (R15) overflow flags never clear by hardware, only by software writing zero
// (R16) software reads both flags to find the source and clears them
// (R17) software should keep low interrupt enable clear in sixteen-bit mode
// (R18) control bits 4 and 1 read zero and ignore writes
// (R19) reload value held in two writable reload bytes
// (R20) count bytes are readable and writable in both modes
// (R21) interrupt level while high flag, or low flag with low enable, is set
// (R22) hardware flag set beats a same-cycle software clear
module dmat_timer
	import dmat_pkg::*;
	#(
	parameter int unsigned SYS_DIV = `DMAT_SYS_DIV,
	parameter int unsigned EXT_DIV = `DMAT_EXT_DIV
	)
	(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_bit_wr_i,
	input wire logic [2:0] sfr_bit_pos_i,
	input wire logic sfr_bit_val_i,
	input wire logic timer_irq_enable_i,
	input wire logic high_byte_clock_select_i,
	input wire logic low_byte_clock_select_i,
	input wire logic ext_clk_i,
	output logic [7:0] sfr_rdata_o,
	output logic irq_o
	);

	// control register fields
	logic high_overflow_flag;
	logic low_overflow_flag;
	logic low_byte_irq_enable;
	logic split_mode_select;
	logic run_control;
	logic external_source_select;

	// data registers
	logic [7:0] count_low_byte;
	logic [7:0] count_high_byte;
	logic [7:0] reload_low_byte;
	logic [7:0] reload_high_byte;

	// prescaled ticks
	logic div12_tick;
	logic ext8_tick;

	// derived control
	dmat_mode_t mode;
	dmat_src_t src_lo;
	dmat_src_t src_hi;
	logic tick_lo;
	logic tick_hi;
	logic [7:0] ctrl_now;
	logic [7:0] ctrl_wdata;
	logic ctrl_we;
	logic we_rld_lo;
	logic we_rld_hi;
	logic we_cnt_lo;
	logic we_cnt_hi;
	logic step_lo;
	logic step_hi;
	logic wrap_lo;
	logic wrap_hi;
	logic [7:0] next_count_low_byte;
	logic [7:0] next_count_high_byte;

	dmat_tick_gen
		#(
		.SYS_DIV(SYS_DIV),
		.EXT_DIV(EXT_DIV)
		)
	dmat_tick_gen_inst
		(
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.ext_clk_i(ext_clk_i),
		.div12_tick_o(div12_tick),
		.ext8_tick_o(ext8_tick)
		);

	// select a clock source; wide mode takes the low-byte select only
	function automatic dmat_src_t pick_src(input logic sys_sel,
		input logic xsel);
		if (sys_sel)
			return DMAT_SRC_SYS; // [R9]
		else if (xsel)
			return DMAT_SRC_EXT8; // [R10]
		else
			return DMAT_SRC_DIV12; // [R10]
	endfunction : pick_src

	function automatic logic src_tick(input dmat_src_t src,
		input logic t12, input logic t8);
		unique case (src)
			DMAT_SRC_SYS: return 1'b1;
			DMAT_SRC_DIV12: return t12;
			DMAT_SRC_EXT8: return t8;
			default: return 1'b0;
		endcase
	endfunction : src_tick

	// mode and per-byte tick selection
	always_comb
	begin
		mode = split_mode_select ? DMAT_MODE_SPLIT : DMAT_MODE_WIDE; // [R2]
		src_lo = pick_src(low_byte_clock_select_i, external_source_select);
		// high select is ignored outside split mode
		if (mode == DMAT_MODE_SPLIT)
			src_hi = pick_src(high_byte_clock_select_i,
				external_source_select);
		else
			src_hi = src_lo;
		tick_lo = src_tick(src_lo, div12_tick, ext8_tick);
		tick_hi = src_tick(src_hi, div12_tick, ext8_tick);
	end

	// current control byte; unused bits are always zero
	always_comb
	begin
		ctrl_now = `DMAT_BYTE_RESET;
		ctrl_now[`DMAT_BIT_HOF] = high_overflow_flag;
		ctrl_now[`DMAT_BIT_LOF] = low_overflow_flag;
		ctrl_now[`DMAT_BIT_LIEN] = low_byte_irq_enable;
		ctrl_now[`DMAT_BIT_SPLIT] = split_mode_select;
		ctrl_now[`DMAT_BIT_RUN] = run_control;
		ctrl_now[`DMAT_BIT_XSEL] = external_source_select;
	end

	// write decode; a bit write edits one bit of the live control byte
	always_comb
	begin
		ctrl_we = (sfr_addr_i == `DMAT_ADDR_CTRL) &&
			(sfr_wr_i || sfr_bit_wr_i);
		ctrl_wdata = sfr_wdata_i;
		if (sfr_bit_wr_i)
		begin
			ctrl_wdata = ctrl_now;
			ctrl_wdata[sfr_bit_pos_i] = sfr_bit_val_i;
		end
		we_rld_lo = sfr_wr_i && (sfr_addr_i == `DMAT_ADDR_RLD_LO);
		we_rld_hi = sfr_wr_i && (sfr_addr_i == `DMAT_ADDR_RLD_HI);
		we_cnt_lo = sfr_wr_i && (sfr_addr_i == `DMAT_ADDR_CNT_LO);
		we_cnt_hi = sfr_wr_i && (sfr_addr_i == `DMAT_ADDR_CNT_HI);
	end

	// counting: which bytes advance, and where they wrap
	always_comb
	begin
		next_count_low_byte = count_low_byte;
		next_count_high_byte = count_high_byte;
		step_lo = 1'b0;
		step_hi = 1'b0;
		wrap_lo = 1'b0;
		wrap_hi = 1'b0;
		if (mode == DMAT_MODE_WIDE)
		begin
			// one sixteen-bit counter, gated as a whole
			step_lo = run_control && tick_lo; // [R8]
			step_hi = step_lo;
			if (step_lo)
			begin
				wrap_lo = (count_low_byte == `DMAT_BYTE_MAX);
				if ({count_high_byte, count_low_byte} == `DMAT_WORD_MAX)
				begin
					wrap_hi = 1'b1;
					next_count_high_byte = reload_high_byte; // [R3]
					next_count_low_byte = reload_low_byte; // [R3]
				end
				else
				begin
					{next_count_high_byte, next_count_low_byte} =
						{count_high_byte, count_low_byte} +
						`DMAT_WORD_ONE; // [R1]
				end
			end
		end
		else
		begin
			// low half free-running, high half under run control
			step_lo = tick_lo; // [R7]
			step_hi = run_control && tick_hi; // [R7]
			if (step_lo)
			begin
				wrap_lo = (count_low_byte == `DMAT_BYTE_MAX);
				next_count_low_byte = wrap_lo ? reload_low_byte :
					count_low_byte + `DMAT_BYTE_ONE; // [R6]
			end
			if (step_hi)
			begin
				wrap_hi = (count_high_byte == `DMAT_BYTE_MAX);
				next_count_high_byte = wrap_hi ? reload_high_byte :
					count_high_byte + `DMAT_BYTE_ONE; // [R6]
			end
		end
	end

	// count bytes; a software write to a byte beats its own increment
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			count_low_byte <= `DMAT_BYTE_RESET;
			count_high_byte <= `DMAT_BYTE_RESET;
		end
		else
		begin
			count_low_byte <= we_cnt_lo ? sfr_wdata_i :
				next_count_low_byte; // [R20]
			count_high_byte <= we_cnt_hi ? sfr_wdata_i :
				next_count_high_byte; // [R20]
		end
	end

	// reload bytes, software written only
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			reload_low_byte <= `DMAT_BYTE_RESET;
			reload_high_byte <= `DMAT_BYTE_RESET;
		end
		else
		begin
			if (we_rld_lo)
				reload_low_byte <= sfr_wdata_i; // [R19]
			if (we_rld_hi)
				reload_high_byte <= sfr_wdata_i; // [R19]
		end
	end

	// plain control fields; bits 4 and 1 have no storage
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			low_byte_irq_enable <= 1'b0;
			split_mode_select <= 1'b0;
			run_control <= 1'b0;
			external_source_select <= 1'b0;
		end
		else if (ctrl_we)
		begin
			low_byte_irq_enable <= ctrl_wdata[`DMAT_BIT_LIEN];
			split_mode_select <= ctrl_wdata[`DMAT_BIT_SPLIT]; // [R2]
			run_control <= ctrl_wdata[`DMAT_BIT_RUN];
			external_source_select <= ctrl_wdata[`DMAT_BIT_XSEL];
		end
	end

	// sticky overflow flags; hardware set wins so no wrap is lost
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			high_overflow_flag <= 1'b0;
			low_overflow_flag <= 1'b0;
		end
		else
		begin
			if (wrap_hi)
				high_overflow_flag <= 1'b1; // [R3] [R12] [R22]
			else if (ctrl_we)
				high_overflow_flag <= ctrl_wdata[`DMAT_BIT_HOF]; // [R15]
			if (wrap_lo)
				low_overflow_flag <= 1'b1; // [R12] [R13] [R22]
			else if (ctrl_we)
				low_overflow_flag <= ctrl_wdata[`DMAT_BIT_LOF]; // [R15]
		end
	end

	// interrupt level, one cycle behind the flags
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= timer_irq_enable_i && (high_overflow_flag ||
				(low_overflow_flag && low_byte_irq_enable)); // [R4] [R5] [R14] [R21]
	end

	// registered read data; unmapped addresses return zero
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			sfr_rdata_o <= `DMAT_BYTE_RESET;
		else
		begin
			unique case (sfr_addr_i)
				`DMAT_ADDR_CTRL: sfr_rdata_o <= ctrl_now; // [R18]
				`DMAT_ADDR_RLD_LO: sfr_rdata_o <= reload_low_byte;
				`DMAT_ADDR_RLD_HI: sfr_rdata_o <= reload_high_byte;
				`DMAT_ADDR_CNT_LO: sfr_rdata_o <= count_low_byte; // [R20]
				`DMAT_ADDR_CNT_HI: sfr_rdata_o <= count_high_byte; // [R20]
				default: sfr_rdata_o <= `DMAT_BYTE_RESET;
			endcase
		end
	end

endmodule : dmat_timer

// ==== verif/dmat_timer_sva.sv ====
`timescale 1ns/100ps
`include "dmat_params.svh"

module dmat_timer_sva
	(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_bit_wr_i,
	input wire logic [2:0] sfr_bit_pos_i,
	input wire logic sfr_bit_val_i,
	input wire logic timer_irq_enable_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic irq_o
	);
	default clocking dcb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	// read data trails the address by one cycle
	a_unmapped_reads_zero: assert property (
		!(sfr_addr_i inside {8'hC8, [8'hCA:8'hCD]}) |=> sfr_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_unused_bits_zero: assert property (
		sfr_addr_i == `DMAT_ADDR_CTRL |=> !sfr_rdata_o[4] && !sfr_rdata_o[1])
		else $error("unused control bit set");
	a_irq_needs_enable: assert property (
		!timer_irq_enable_i |=> !irq_o)
		else $error("irq without enable");
	// irq and the flags it reads come from the same cycle
	a_irq_level_flags: assert property (
		sfr_addr_i == `DMAT_ADDR_CTRL && timer_irq_enable_i |=>
		irq_o == (sfr_rdata_o[7] | (sfr_rdata_o[6] & sfr_rdata_o[5])))
		else $error("irq level disagrees with flags");
	a_high_flag_sticky: assert property (
		(sfr_addr_i == 8'hC8 && !sfr_wr_i && !sfr_bit_wr_i) ##1
		(sfr_addr_i == 8'hC8 && sfr_rdata_o[7]) |=> sfr_rdata_o[7])
		else $error("high flag cleared by hardware");
	a_low_flag_sticky: assert property (
		(sfr_addr_i == 8'hC8 && !sfr_wr_i && !sfr_bit_wr_i) ##1
		(sfr_addr_i == 8'hC8 && sfr_rdata_o[6]) |=> sfr_rdata_o[6])
		else $error("low flag cleared by hardware");
	// flags excluded: hardware may set them meanwhile
	a_ctrl_write_back: assert property (
		(sfr_wr_i && sfr_addr_i == 8'hC8) ##1 sfr_addr_i == 8'hC8 |=>
		(sfr_rdata_o & 8'h2D) == ($past(sfr_wdata_i, 2) & 8'h2D))
		else $error("control byte write lost");
	a_run_bit_write: assert property (
		(sfr_bit_wr_i && sfr_addr_i == 8'hC8 && sfr_bit_pos_i == 3'h2) ##1
		sfr_addr_i == 8'hC8 |=> sfr_rdata_o[2] == $past(sfr_bit_val_i, 2))
		else $error("run bit write lost");
	a_data_write_back: assert property (
		(sfr_wr_i && sfr_addr_i inside {[8'hCA:8'hCD]}) ##1
		sfr_addr_i == $past(sfr_addr_i) |=> sfr_rdata_o == $past(sfr_wdata_i, 2))
		else $error("data byte write lost");

	c_high_flag: cover property (sfr_addr_i == 8'hC8 ##1 sfr_rdata_o[7]);
	c_low_irq: cover property (sfr_addr_i == 8'hC8 ##1 sfr_rdata_o[5] && irq_o);
	c_irq_seen: cover property ($rose(irq_o));
endmodule : dmat_timer_sva

bind dmat_timer dmat_timer_sva dmat_timer_sva_inst (.mclk_i(mclk_i),
	.rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
	.sfr_wdata_i(sfr_wdata_i), .sfr_bit_wr_i(sfr_bit_wr_i),
	.sfr_bit_pos_i(sfr_bit_pos_i), .sfr_bit_val_i(sfr_bit_val_i),
	.timer_irq_enable_i(timer_irq_enable_i), .sfr_rdata_o(sfr_rdata_o),
	.irq_o(irq_o));

// ==== verif/dmat_timer_tb.sv ====
`timescale 1ns/100ps

module dmat_timer_tb;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] addr = 8'h00;
	logic wr = 1'b0;
	logic [7:0] wd = 8'h00;
	logic bwr = 1'b0;
	logic [2:0] bpos = 3'h0;
	logic bval = 1'b0;
	logic ie = 1'b0;
	logic hs = 1'b0;
	logic ls = 1'b1;
	logic xclk = 1'b0;
	logic [7:0] rdata;
	logic irq;
	logic rd_go = 1'b0;
	logic rd_d = 1'b0;
	logic ir_go = 1'b0;
	logic ir_d = 1'b0;
	logic [15:0] rq[$];
	logic iq[$];
	logic [15:0] note;
	logic [7:0] rv;
	logic [7:0] al [6] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hCE};
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	int seed = 32'h2F28;
	int k;

	// system clock, and a slower external source of unrelated phase
	initial forever #50 mclk_i = ~mclk_i;
	initial
	begin
		#37;
		forever #125 xclk = ~xclk;
	end

	dmat_timer dmat_timer_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wd),
		.sfr_bit_wr_i(bwr), .sfr_bit_pos_i(bpos), .sfr_bit_val_i(bval),
		.timer_irq_enable_i(ie), .high_byte_clock_select_i(hs),
		.low_byte_clock_select_i(ls), .ext_clk_i(xclk),
		.sfr_rdata_o(rdata), .irq_o(irq));

	task automatic print_verdict;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	task automatic cmp_byte(input logic [7:0] e, input logic [7:0] m);
		n_compared++;
		if ((rdata & m) !== (e & m))
		begin
			num_errors++;
			$display("[FAIL] sfr_rdata_o exp %h mask %h got %h", e, m, rdata);
		end
	endtask : cmp_byte

	task automatic cmp_irq(input logic e);
		n_compared++;
		if (irq !== e)
		begin
			num_errors++;
			$display("[FAIL] irq_o exp %b got %b", e, irq);
		end
	endtask : cmp_irq

	// one cycle after a sampled read the result stands; take oldest note
	always @(posedge mclk_i)
	begin
		rd_d <= rd_go;
		ir_d <= ir_go;
		cycles++;
		if (cycles > 3000)
		begin
			num_errors++;
			print_verdict();
		end
	end
	always @(negedge mclk_i)
	begin
		if (rd_d)
		begin
			note = rq.pop_front();
			cmp_byte(note[7:0], note[15:8]);
		end
		if (ir_d)
			cmp_irq(iq.pop_front());
	end

	task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		#1;
		addr = a;
		wd = d;
		wr = 1'b1;
		@(posedge mclk_i);
		#1;
		wr = 1'b0;
	endtask : wr_b

	// bit writes reach the control register only
	task automatic bit_w(input logic [2:0] p, input logic v);
		@(posedge mclk_i);
		#1;
		addr = 8'hC8;
		bpos = p;
		bval = v;
		bwr = 1'b1;
		@(posedge mclk_i);
		#1;
		bwr = 1'b0;
	endtask : bit_w

	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input logic [7:0] m);
		@(posedge mclk_i);
		#1;
		addr = a;
		rd_go = 1'b1;
		rq.push_back({m, e});
		@(posedge mclk_i);
		#1;
		rd_go = 1'b0;
	endtask : rd

	task automatic ci(input logic e);
		@(posedge mclk_i);
		#1;
		ir_go = 1'b1;
		iq.push_back(e);
		@(posedge mclk_i);
		#1;
		ir_go = 1'b0;
	endtask : ci

	// main sequence
	initial
	begin
		#151;
		rst_n_i = 1'b1;
		for (k = 0; k < 6; k++)
			rd(al[k], 8'h00, 8'hFF);
		wr_b(8'hCE, 8'h5A);
		rd(8'hCE, 8'h00, 8'hFF);
		wr_b(8'hC8, 8'h12);
		rd(8'hC8, 8'h00, 8'hFF);
		// stopped wide timer keeps what was written
		for (k = 1; k < 5; k++)
		begin
			rv = $random(seed);
			wr_b(al[k], rv);
			repeat (3) @(posedge mclk_i);
			rd(al[k], rv, 8'hFF);
		end
		// wide wrap from FFFE with reload 1234
		wr_b(8'hCA, 8'h34);
		wr_b(8'hCB, 8'h12);
		wr_b(8'hCC, 8'hFE);
		wr_b(8'hCD, 8'hFF);
		ie = 1'b1;
		bit_w(3'h2, 1'b1);
		repeat (8) @(posedge mclk_i);
		bit_w(3'h2, 1'b0);
		rd(8'hC8, 8'hC0, 8'hFF);
		rd(8'hCD, 8'h12, 8'hFF);
		rd(8'hCC, 8'h30, 8'hF0);
		ci(1'b1);
		ie = 1'b0;
		ci(1'b0);
		ie = 1'b1;
		bit_w(3'h7, 1'b0);
		ci(1'b0);
		bit_w(3'h5, 1'b1);
		ci(1'b1);
		repeat (30) @(posedge mclk_i);
		rd(8'hC8, 8'h60, 8'hFF);
		bit_w(3'h6, 1'b0);
		ci(1'b0);
		// low wraps on the very edge that clears its flag and stops the run
		wr_b(8'hCC, 8'hFE);
		wr_b(8'hC8, 8'h04);
		wr_b(8'hC8, 8'h00);
		rd(8'hC8, 8'h40, 8'hFF);
		// split, high half stopped, low half wraps from F0
		wr_b(8'hCA, 8'hF0);
		wr_b(8'hCC, 8'hF0);
		wr_b(8'hCD, 8'h55);
		wr_b(8'hC8, 8'h08);
		repeat (40) @(posedge mclk_i);
		rd(8'hCD, 8'h55, 8'hFF);
		rd(8'hC8, 8'h48, 8'hFF);
		rd(8'hCC, 8'hF0, 8'hF0);
		ci(1'b0);
		bit_w(3'h5, 1'b1);
		ci(1'b1);
		wr_b(8'hC8, 8'h00);
		// divided sources: about nine or ten ticks in each window
		ls = 1'b0;
		for (k = 0; k < 2; k++)
		begin
			wr_b(8'hC8, {7'h06, k[0]});
			wr_b(8'hCC, 8'h00);
			wr_b(8'hCD, 8'h00);
			repeat (k ? 186 : 110) @(posedge mclk_i);
			rd(8'hCC, 8'h08, 8'hFC);
			rd(8'hCD, 8'h08, 8'hFC);
		end
		// split high half on the system clock wraps to its own reload
		hs = 1'b1;
		wr_b(8'hCB, 8'hA0);
		wr_b(8'hCD, 8'hF8);
		repeat (8) @(posedge mclk_i);
		rd(8'hC8, 8'h8D, 8'hBF);
		rd(8'hCD, 8'hA3, 8'hFF);
		ci(1'b1);
		repeat (3) @(posedge mclk_i);
		print_verdict();
	end
endmodule : dmat_timer_tb
